//--- hdl/port_irq_pkg.sv
// Purpose: shared constants for the port latch and outside interrupt block
// Assumes: 8-bit register bus, byte offsets as printed
// Notes: edge sense choice register sits beside the enables as an input-facing register
package port_irq_pkg;
   localparam int DATA_W = 8; // register data width
   localparam int ADDR_W = 8; // register address width
   localparam int PIN_N = 7; // port pins
   localparam int IRQ_N = 3; // outside interrupt pins
   localparam logic [7:0] OFS_LATCH = 8'h00; // port output latch
   localparam logic [7:0] OFS_FLAGS = 8'h01; // edge detect flags
   localparam logic [7:0] OFS_ENABLES = 8'h02; // interrupt enables
   localparam logic [7:0] OFS_SENSE = 8'h03; // edge sense choice register
   localparam logic [6:0] RST_LATCH = 7'h7F; // latch reset value
   localparam logic [2:0] RST_FLAGS = 3'h0; // flags reset value
   localparam logic [2:0] RST_ENABLES = 3'h0; // enables reset value
   localparam logic [2:0] RST_SENSE = 3'h0; // sense reset value
   localparam logic [7:0] READ_ZERO = 8'h00; // unmapped read answer
   localparam logic SENSE_RISE = 1'b0; // choice 0 selects rising edge
endpackage

//--- hdl/pin_sync.sv
// Purpose: two-flop synchroniser for a group of pins
// Assumes: single clock, clock enable freezes state
// Notes: first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage1; // metastability catch stage
   // two flops in series
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stage1 <= '0;
         dout <= '0;
      end else if (ce) begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule
`default_nettype wire

//--- hdl/edge_pick.sv
// Purpose: chosen-edge detector per interrupt pin
// Assumes: inputs already synchronised
// Notes: pulse is one cycle wide per edge
`timescale 1ns/1ns
`default_nettype none
module edge_pick #(
   parameter int W = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] level,
   input wire logic [W-1:0] falling_sel,
   output logic [W-1:0] hit
);
   logic [W-1:0] prev; // last sampled level
   wire [W-1:0] rise = level & ~prev; // rising seen
   wire [W-1:0] fall = ~level & prev; // falling seen
   assign hit = ce ? ((rise & ~falling_sel) | (fall & falling_sel)) : '0;
   // level history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= '0;
      end else if (ce) begin
         prev <= level;
      end
   end
endmodule
`default_nettype wire

//--- hdl/port_out_and_ext_irq.sv
// Purpose: port output latch plus three outside interrupt flags and enables
// Assumes: plain register port, read data one cycle after the read strobe
// Notes: port direction lives elsewhere; pins follow the latch directly
// Notes on behaviour
// - port latch resets to 7F
// - latch low seven bits drive pins
// - latch read returns stored value
// - direction change leaves latch alone
// - reserved bits read zero
// - flags and enables reset to zero
// - flag sets on selected pin edge
// - request when flag and enable both set
// - flag holds until software clears
// - enable one allows requests
// - enable zero blocks requests
// - sense zero rising, one falling
`timescale 1ns/1ns
`default_nettype none
module port_out_and_ext_irq #(
   parameter int PIN_N = port_irq_pkg::PIN_N,
   parameter int IRQ_N = port_irq_pkg::IRQ_N
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [IRQ_N-1:0] outside_irq_pin,
   output logic [PIN_N-1:0] port_pins,
   output logic irq_request
);
   // register state
   logic [PIN_N-1:0] port_zero_output_latch; // port output latch
   logic [IRQ_N-1:0] edge_detect_flag; // sticky edge flags
   logic [IRQ_N-1:0] outside_irq_enable_bit; // per-pin enables
   logic [IRQ_N-1:0] edge_sense_choice; // 1 = falling edge
   logic [IRQ_N-1:0] pin_synced; // synchronised pins
   logic [IRQ_N-1:0] edge_hit; // one-cycle edge pulses

   // address match against one register offset
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // address decode
   wire sel_latch = reg_hit(addr, port_irq_pkg::OFS_LATCH); // latch hit
   wire sel_flags = reg_hit(addr, port_irq_pkg::OFS_FLAGS); // flags hit
   wire sel_enables = reg_hit(addr, port_irq_pkg::OFS_ENABLES); // enables hit
   wire sel_sense = reg_hit(addr, port_irq_pkg::OFS_SENSE); // sense hit
   wire wr_latch = wr & sel_latch; // latch write
   wire wr_flags = wr & sel_flags; // flags write
   wire wr_enables = wr & sel_enables; // enables write
   wire wr_sense = wr & sel_sense; // sense write

   // flags held, cleared only by write
   wire [IRQ_N-1:0] next_flags = (wr_flags ? wdata[IRQ_N-1:0] : edge_detect_flag) | edge_hit;
   wire [IRQ_N-1:0] flag_set_view = edge_hit;
   // flag and enable make a request
   // enables as they stand after this edge
   wire [IRQ_N-1:0] next_enables = wr_enables ? wdata[IRQ_N-1:0] : outside_irq_enable_bit;
   wire next_request = |(next_flags & next_enables);

   wire [7:0] next_rdata = sel_latch ? {1'b0, port_zero_output_latch} :
      sel_flags ? {5'h00, edge_detect_flag} :
      sel_enables ? {5'h00, outside_irq_enable_bit} :
      sel_sense ? {5'h00, edge_sense_choice} : port_irq_pkg::READ_ZERO;

   pin_sync #(.W(IRQ_N)) u_sync (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .din(outside_irq_pin),
      .dout(pin_synced)
   );

   // edge detection per pin
   edge_pick #(.W(IRQ_N)) u_edge (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .level(pin_synced),
      .falling_sel(edge_sense_choice),
      .hit(edge_hit)
   );

   // latch reset and only write changes it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_zero_output_latch <= port_irq_pkg::RST_LATCH;
      end else if (ce && wr_latch) begin
         port_zero_output_latch <= wdata[PIN_N-1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         port_pins <= port_irq_pkg::RST_LATCH;
      end else if (ce) begin
         port_pins <= wr_latch ? wdata[PIN_N-1:0] : port_zero_output_latch;
      end
   end

   // flags and enables reset to zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         edge_detect_flag <= port_irq_pkg::RST_FLAGS;
         outside_irq_enable_bit <= port_irq_pkg::RST_ENABLES;
         edge_sense_choice <= port_irq_pkg::RST_SENSE;
      end else if (ce) begin
         edge_detect_flag <= next_flags;
         if (wr_enables) begin
            outside_irq_enable_bit <= wdata[IRQ_N-1:0];
         end
         if (wr_sense) begin
            edge_sense_choice <= wdata[IRQ_N-1:0];
         end
      end
   end

   // registered request and read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_request <= 1'b0;
         rdata <= port_irq_pkg::READ_ZERO;
      end else if (ce) begin
         irq_request <= next_request;
         rdata <= rd ? next_rdata : port_irq_pkg::READ_ZERO;
      end
   end

   // assertions
   latch_reset_a: assert property (@(posedge clk) $fell(rst) |->
      port_zero_output_latch == port_irq_pkg::RST_LATCH)
      else $error("latch not 7F after reset");
   pins_follow_a: assert property (@(posedge clk) disable iff (rst)
      ce && !wr_latch |=> port_pins == $past(port_zero_output_latch))
      else $error("pins differ from latch");
   latch_read_a: assert property (@(posedge clk) disable iff (rst)
      ce && rd && sel_latch |=> rdata == {1'b0, $past(port_zero_output_latch)})
      else $error("latch read wrong");
   latch_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(wr && sel_latch) |=> $stable(port_zero_output_latch))
      else $error("latch changed without write");
   reserved_zero_a: assert property (@(posedge clk) disable iff (rst)
      rdata[7] == 1'b0 && (!$past(sel_latch) -> rdata[7:3] == 5'h00))
      else $error("reserved bits nonzero");
   flags_reset_a: assert property (@(posedge clk) $fell(rst) |->
      edge_detect_flag == 3'h0 && outside_irq_enable_bit == 3'h0)
      else $error("flags or enables not zero after reset");
   flag_set_a: assert property (@(posedge clk) disable iff (rst)
      ce && |flag_set_view |=> (edge_detect_flag & $past(flag_set_view)) == $past(flag_set_view))
      else $error("edge did not set flag");
   request_a: assert property (@(posedge clk) disable iff (rst)
      ce |=> irq_request == |($past(next_flags) & outside_irq_enable_bit))
      else $error("request mismatch");
   flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
      !(wr && sel_flags) |=> (edge_detect_flag & $past(edge_detect_flag)) == $past(edge_detect_flag))
      else $error("flag cleared itself");
   enable_block_a: assert property (@(posedge clk) disable iff (rst)
      ce && outside_irq_enable_bit == 3'h0 && !wr_enables |=> !irq_request)
      else $error("request while disabled");
   set_wins_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_flags && edge_hit[0] |=> edge_detect_flag[0])
      else $error("clear beat edge");

   // reset values seen at the first edge after release

   // pins show reset latch value
   pins_reset_a: assert property (@(posedge clk) $fell(rst) |->
      port_pins == port_irq_pkg::RST_LATCH)
      else $error("pins not 7F after reset");

   // sense choice cleared by reset
   sense_reset_a: assert property (@(posedge clk) $fell(rst) |->
      edge_sense_choice == port_irq_pkg::RST_SENSE)
      else $error("sense choice not zero after reset");

   // no request straight after reset
   request_reset_a: assert property (@(posedge clk) $fell(rst) |->
      !irq_request)
      else $error("request after reset");

   // latch and pin behaviour

   // pins always mirror the latch
   pins_mirror_a: assert property (@(posedge clk)
      port_pins == port_zero_output_latch)
      else $error("pins and latch disagree");

   // written value lands in latch
   latch_write_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_latch |=> port_zero_output_latch == $past(wdata[PIN_N-1:0]))
      else $error("latch write lost");

   // written value reaches pins
   pins_write_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_latch |=> port_pins == $past(wdata[PIN_N-1:0]))
      else $error("pins missed write");

   // read bus behaviour

   // idle read data is zero
   rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
      ce && !rd |=> rdata == port_irq_pkg::READ_ZERO)
      else $error("read data not idle");

   // flags read with zero top bits
   flags_read_a: assert property (@(posedge clk) disable iff (rst)
      ce && rd && sel_flags |=> rdata == {5'h00, $past(edge_detect_flag)})
      else $error("flags read wrong");

   // enables read with zero top bits
   enables_read_a: assert property (@(posedge clk) disable iff (rst)
      ce && rd && sel_enables |=> rdata == {5'h00, $past(outside_irq_enable_bit)})
      else $error("enables read wrong");

   // unmapped address reads zero
   unmapped_read_a: assert property (@(posedge clk) disable iff (rst)
      ce && rd && !(sel_latch || sel_flags || sel_enables || sel_sense)
      |=> rdata == port_irq_pkg::READ_ZERO)
      else $error("unmapped read nonzero");

   // flag and enable behaviour

   // software write stores flags
   flag_write_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_flags && !(|edge_hit) |=> edge_detect_flag == $past(wdata[IRQ_N-1:0]))
      else $error("flag write lost");

   // quiet cycle keeps flags
   flag_quiet_a: assert property (@(posedge clk) disable iff (rst)
      ce && !wr_flags && !(|edge_hit) |=> $stable(edge_detect_flag))
      else $error("flags moved on their own");

   // enable write lands
   enable_write_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_enables |=> outside_irq_enable_bit == $past(wdata[IRQ_N-1:0]))
      else $error("enable write lost");

   // enabled flag raises request
   enable_allow_a: assert property (@(posedge clk) disable iff (rst)
      ce && |(next_flags & next_enables) |=> irq_request)
      else $error("enabled flag gave no request");

   // standing flag keeps request
   flag_request_a: assert property (@(posedge clk) disable iff (rst)
      ce && !wr_flags && !wr_enables && |(edge_detect_flag & outside_irq_enable_bit)
      |=> irq_request)
      else $error("request dropped");

   // edge choice behaviour

   // sense write lands
   sense_write_a: assert property (@(posedge clk) disable iff (rst)
      ce && wr_sense |=> edge_sense_choice == $past(wdata[IRQ_N-1:0]))
      else $error("sense write lost");

   // rising edge caught on pin 0
   rise_hit_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && !edge_sense_choice[0] && $rose(pin_synced[0])
      |-> edge_hit[0])
      else $error("rising edge missed");

   // rising edge caught on pin 2
   rise_two_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && !edge_sense_choice[2] && $rose(pin_synced[2])
      |-> edge_hit[2])
      else $error("rising edge missed on pin 2");

   // falling edge caught on pin 0
   fall_hit_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && edge_sense_choice[0] && $fell(pin_synced[0])
      |-> edge_hit[0])
      else $error("falling edge missed");

   // falling edge caught on pin 1
   fall_one_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && edge_sense_choice[1] && $fell(pin_synced[1])
      |-> edge_hit[1])
      else $error("falling edge missed on pin 1");

   // unchosen edge ignored
   wrong_edge_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && edge_sense_choice[0] && $rose(pin_synced[0])
      |-> !edge_hit[0])
      else $error("wrong edge accepted");

   // two flop delay through synchroniser
   sync_delay_a: assert property (@(posedge clk) disable iff (rst)
      ce && $past(ce) && $past(ce, 2) && !$past(rst) && !$past(rst, 2)
      |-> pin_synced == $past(outside_irq_pin, 2))
      else $error("synchroniser delay wrong");

   // scenario covers
   cover_request: cover property (@(posedge clk) disable iff (rst) $rose(irq_request));
   cover_falling: cover property (@(posedge clk) disable iff (rst) edge_sense_choice[1] && edge_hit[1]);
   cover_clash: cover property (@(posedge clk) disable iff (rst) wr_flags && |edge_hit);
   cover_latch_rd: cover property (@(posedge clk) disable iff (rst) rd && sel_latch);
endmodule
`default_nettype wire

//--- test/core_model.sv
// Purpose: processor core model driving the register port
// Assumes: one cycle strobes, read data stands in the next cycle only
// Notes: bench calls its tasks by hierarchical name
`timescale 1ns/1ns
`default_nettype none
module core_model (
   input wire logic clk,
   output var logic [7:0] addr,
   output var logic [7:0] wdata,
   output var logic wr,
   output var logic rd,
   input wire logic [7:0] rdata
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // one write cycle, data scrambled once released
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
      #1;
   endtask
   // one read cycle, data taken in the following cycle
   task automatic get(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic service();
      put(port_irq_pkg::OFS_FLAGS, 8'h00);
   endtask
endmodule
`default_nettype wire

//--- test/port_out_and_ext_irq_bench.sv
// Purpose: self-checking bench for port latch and outside interrupts
// Assumes: core model owns the register port
// Notes: random latch data from a fixed lfsr seed
`timescale 1ns/1ns
`default_nettype none
module port_out_and_ext_irq_bench;
   logic clk = 1'b0; // system clock
   logic rst = 1'b1; // async reset
   logic [2:0] pins = 3'h0; // interrupt pin levels
   logic [7:0] addr, wdata, rdata, d; // bus and read value
   logic wr, rd, irq_request;
   logic [6:0] port_pins;
   logic [31:0] seed = 32'h30E6; // lfsr state
   int miscompares = 0;
   int compares = 0;
   always #5 clk = ~clk;
   port_out_and_ext_irq i_dut (.clk(clk), .rst(rst), .ce(1'b1), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .outside_irq_pin(pins),
      .port_pins(port_pins), .irq_request(irq_request));
   core_model i_core (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   // next lfsr value
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // compare one value
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %0t got %h want %h", $time, got, exp);
      end
   endtask
   // read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      i_core.get(a, d);
      check(d, exp);
   endtask
   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // run limit
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rchk(8'h00, 8'h7F);
      check({1'b0, port_pins}, 8'h7F);
      rchk(8'h01, 8'h00);
      rchk(8'h02, 8'h00);
      rchk(8'h10, 8'h00);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         i_core.put(8'h00, seed[7:0]);
         check({1'b0, port_pins}, {1'b0, seed[6:0]});
         rchk(8'h00, {1'b0, seed[6:0]});
      end
      for (int i = 0; i < 3; i++) begin
         for (int s = 0; s < 2; s++) begin
            i_core.put(8'h03, 8'(s << i));
            pins[i] <= s[0];
            repeat (4) @(posedge clk);
            i_core.service();
            pins[i] <= ~s[0];
            repeat (5) @(posedge clk);
            rchk(8'h01, 8'(1 << i));
            pins[i] <= s[0];
            repeat (8) @(posedge clk);
            rchk(8'h01, 8'(1 << i));
            i_core.service();
            pins[i] <= ~s[0];
            pins[i] <= s[0];
            repeat (5) @(posedge clk);
            rchk(8'h01, 8'h00);
         end
      end
      pins[0] <= 1'b0;
      repeat (4) @(posedge clk);
      pins[0] <= 1'b1;
      @(posedge clk);
      i_core.put(8'h01, 8'h00);
      rchk(8'h01, 8'h01);
      i_core.put(8'h01, 8'hFF);
      rchk(8'h01, 8'h07);
      i_core.put(8'h02, 8'hF8);
      check({7'h00, irq_request}, 8'h00);
      i_core.put(8'h01, 8'h01);
      i_core.put(8'h02, 8'h01);
      check({7'h00, irq_request}, 8'h01);
      i_core.put(8'h02, 8'h06);
      check({7'h00, irq_request}, 8'h00);
      rchk(8'h02, 8'h06);
      i_core.put(8'h02, 8'hFF);
      i_core.service();
      check({7'h00, irq_request}, 8'h00);
      i_core.put(8'h00, 8'h00);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rchk(8'h00, 8'h7F);
      rchk(8'h02, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
